//--- gpb_pkg.sv
// What this block does
// - Direction one makes pin output from latch
// - Direction zero makes pin input, undriven
// - Output pin level equals latch bit
// - Data write updates latch and output pins
// - Data write updates latch of input pins
// - Output pin read returns latch bit
// - Input read returns pin; RMW returns latch
// - Peripheral input pins still read pin level
// - Reset clears all direction bits
// - Standby with select forces all pins Hi-Z
// - Forced standby blocks f_in_o/g_in_o, holds low; data reads of input bits still see pin
// - Enabled interrupt input stays unblocked
// - Select zero keeps pin states in standby
// - Pull-up enable connects internal pull-up
// - Pull-up off while pin drives low
// - Open-drain latch one releases pin
package gpb_pkg;
  localparam int GPB_AW = 4;
  localparam int GPB_DW = 8;
  localparam logic [3:0] GPB_OFS_F_DATA = 4'h0;
  localparam logic [3:0] GPB_OFS_F_DIR = 4'h1;
  localparam logic [3:0] GPB_OFS_G_DATA = 4'h2;
  localparam logic [3:0] GPB_OFS_G_DIR = 4'h3;
  localparam logic [3:0] GPB_OFS_G_PULL = 4'h4;
  localparam logic [3:0] GPB_OFS_STBY = 4'h5;
  // Implemented bits per register
  localparam logic [7:0] GPB_F_MASK = 8'h07;
  localparam logic [7:0] GPB_G_MASK = 8'h06;
  localparam logic [7:0] GPB_STBY_MASK = 8'h01;
  localparam logic [7:0] GPB_DIR_RST = 8'h00;
  localparam logic [7:0] GPB_DATA_RST = 8'h00;
  localparam logic [7:0] GPB_PULL_RST = 8'h00;
  localparam logic [7:0] GPB_ZERO = 8'h00;
  localparam int GPB_SPL_BIT = 0;
endpackage

//--- gpb_sync_if.sv
`timescale 1ns/1ns
interface gpb_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

//--- gpb_sync.sv
`timescale 1ns/1ns
module gpb_sync #(
  parameter int W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  gpb_sync_if.dst s
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = s.raw;
    sync_next = meta_reg;
    if (!rst_b_i) begin
      meta_next = '0;
      sync_next = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign s.synced = sync_reg;
endmodule

//--- gpb_pin_cell.sv
`timescale 1ns/1ns
module gpb_pin_cell #(
  parameter logic OPEN_DRAIN = 1'b0
) (
  // Control
  input wire logic latch_i,
  input wire logic dir_i,
  input wire logic pull_en_i,
  input wire logic force_z_i,
  // Pin drive
  output logic out_o,
  output logic oe_o,
  output logic pull_o
);
  logic drive;
  always_comb begin
    // Forced Hi-Z overrides direction
    drive = dir_i && !force_z_i;
    out_o = latch_i;
    oe_o = drive && !(OPEN_DRAIN && latch_i);
    // No pull-up current into a pin held low
    pull_o = pull_en_i && !(oe_o && !latch_i);
  end
endmodule

//--- gpb_port_bank.sv
`timescale 1ns/1ns
module gpb_port_bank
  import gpb_pkg::*;
#(
  parameter logic [7:0] F_OPEN_DRAIN = 8'h00,
  parameter logic [7:0] G_OPEN_DRAIN = 8'h00
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [gpb_pkg::GPB_AW-1:0] addr_i,
  input wire logic [gpb_pkg::GPB_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rmw_i,
  output logic [gpb_pkg::GPB_DW-1:0] rdata_o,
  // Standby controller
  input wire logic stop_watch_i,
  input wire logic [gpb_pkg::GPB_DW-1:0] f_irq_en_i,
  input wire logic [gpb_pkg::GPB_DW-1:0] g_irq_en_i,
  // Port F pins
  input wire logic [gpb_pkg::GPB_DW-1:0] f_pin_i,
  output logic [gpb_pkg::GPB_DW-1:0] f_pin_o,
  output logic [gpb_pkg::GPB_DW-1:0] f_pin_oe_o,
  output logic [gpb_pkg::GPB_DW-1:0] f_in_o,
  // Port G pins
  input wire logic [gpb_pkg::GPB_DW-1:0] g_pin_i,
  output logic [gpb_pkg::GPB_DW-1:0] g_pin_o,
  output logic [gpb_pkg::GPB_DW-1:0] g_pin_oe_o,
  output logic [gpb_pkg::GPB_DW-1:0] g_pull_o,
  output logic [gpb_pkg::GPB_DW-1:0] g_in_o
);
  import gpb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] f_data_reg, f_data_next;
  logic [7:0] f_dir_reg, f_dir_next;
  logic [7:0] g_data_reg, g_data_next;
  logic [7:0] g_dir_reg, g_dir_next;
  logic [7:0] g_pull_reg, g_pull_next;
  logic [7:0] stby_reg, stby_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] f_pin_reg, f_pin_next;
  logic [7:0] f_oe_reg, f_oe_next;
  logic [7:0] f_in_reg, f_in_next;
  logic [7:0] g_pin_reg, g_pin_next;
  logic [7:0] g_oe_reg, g_oe_next;
  logic [7:0] g_pu_reg, g_pu_next;
  logic [7:0] g_in_reg, g_in_next;
  logic [7:0] f_cell_o, f_cell_oe;
  logic [7:0] g_cell_o, g_cell_oe, g_cell_pu;
  logic [7:0] f_sync, g_sync;
  logic force_z;

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs cross from outside through two flops
  gpb_sync_if #(.W(GPB_DW)) f_sif ();
  gpb_sync_if #(.W(GPB_DW)) g_sif ();
  assign f_sif.raw = f_pin_i;
  assign g_sif.raw = g_pin_i;
  assign f_sync = f_sif.synced;
  assign g_sync = g_sif.synced;

  gpb_sync #(.W(GPB_DW)) u_f_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .s(f_sif)
  );
  gpb_sync #(.W(GPB_DW)) u_g_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .s(g_sif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    f_data_next = f_data_reg;
    f_dir_next = f_dir_reg;
    g_data_next = g_data_reg;
    g_dir_next = g_dir_reg;
    g_pull_next = g_pull_reg;
    stby_next = stby_reg;
    if (wr_i) begin
      if (addr_i == GPB_OFS_F_DATA) begin
        f_data_next = wdata_i & GPB_F_MASK;
      end else if (addr_i == GPB_OFS_F_DIR) begin
        f_dir_next = wdata_i & GPB_F_MASK;
      end else if (addr_i == GPB_OFS_G_DATA) begin
        g_data_next = wdata_i & GPB_G_MASK;
      end else if (addr_i == GPB_OFS_G_DIR) begin
        g_dir_next = wdata_i & GPB_G_MASK;
      end else if (addr_i == GPB_OFS_G_PULL) begin
        g_pull_next = wdata_i & GPB_G_MASK;
      end else if (addr_i == GPB_OFS_STBY) begin
        stby_next = wdata_i & GPB_STBY_MASK;
      end
    end
    if (!rst_b_i) begin
      f_data_next = GPB_DATA_RST;
      f_dir_next = GPB_DIR_RST;
      g_data_next = GPB_DATA_RST;
      g_dir_next = GPB_DIR_RST;
      g_pull_next = GPB_PULL_RST;
      stby_next = GPB_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: output bits and RMW reads see latch, else pin
  always_comb begin
    rdata_next = GPB_ZERO;
    if (rd_i) begin
      if (addr_i == GPB_OFS_F_DATA) begin
        rdata_next = rmw_i ? f_data_reg
          : ((f_dir_reg & f_data_reg) | (~f_dir_reg & f_sync));
        rdata_next = rdata_next & GPB_F_MASK;
      end else if (addr_i == GPB_OFS_F_DIR) begin
        rdata_next = f_dir_reg;
      end else if (addr_i == GPB_OFS_G_DATA) begin
        rdata_next = rmw_i ? g_data_reg
          : ((g_dir_reg & g_data_reg) | (~g_dir_reg & g_sync));
        rdata_next = rdata_next & GPB_G_MASK;
      end else if (addr_i == GPB_OFS_G_DIR) begin
        rdata_next = g_dir_reg;
      end else if (addr_i == GPB_OFS_G_PULL) begin
        rdata_next = g_pull_reg;
      end else if (addr_i == GPB_OFS_STBY) begin
        rdata_next = stby_reg;
      end
    end
    if (!rst_b_i) begin
      rdata_next = GPB_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Select one plus stop/watch forces Hi-Z; select zero holds pins
  assign force_z = stby_reg[GPB_SPL_BIT] && stop_watch_i;

  // Software must have turned shared peripheral outputs off
  genvar i;
  generate
    for (i = 0; i < GPB_DW; i++) begin : g_pin
      gpb_pin_cell #(.OPEN_DRAIN(F_OPEN_DRAIN[i])) u_f (
        .latch_i(f_data_reg[i]),
        .dir_i(f_dir_reg[i]),
        .pull_en_i(1'b0),
        .force_z_i(force_z),
        .out_o(f_cell_o[i]),
        .oe_o(f_cell_oe[i]),
        .pull_o()
      );
      gpb_pin_cell #(.OPEN_DRAIN(G_OPEN_DRAIN[i])) u_g (
        .latch_i(g_data_reg[i]),
        .dir_i(g_dir_reg[i]),
        .pull_en_i(g_pull_reg[i]),
        .force_z_i(force_z),
        .out_o(g_cell_o[i]),
        .oe_o(g_cell_oe[i]),
        .pull_o(g_cell_pu[i])
      );
    end
  endgenerate

  always_comb begin
    f_pin_next = f_cell_o & GPB_F_MASK;
    f_oe_next = f_cell_oe & GPB_F_MASK;
    g_pin_next = g_cell_o & GPB_G_MASK;
    g_oe_next = g_cell_oe & GPB_G_MASK;
    g_pu_next = g_cell_pu & GPB_G_MASK;
    // Blocked inputs read low to stop open-input leakage
    f_in_next = force_z ? (f_sync & f_irq_en_i & GPB_F_MASK)
      : (f_sync & GPB_F_MASK);
    g_in_next = force_z ? (g_sync & g_irq_en_i & GPB_G_MASK)
      : (g_sync & GPB_G_MASK);
    if (!rst_b_i) begin
      f_pin_next = GPB_ZERO;
      f_oe_next = GPB_ZERO;
      g_pin_next = GPB_ZERO;
      g_oe_next = GPB_ZERO;
      g_pu_next = GPB_ZERO;
      f_in_next = GPB_ZERO;
      g_in_next = GPB_ZERO;
    end
  end

  always_ff @(posedge core_clk_i) begin
    f_data_reg <= f_data_next;
    f_dir_reg <= f_dir_next;
    g_data_reg <= g_data_next;
    g_dir_reg <= g_dir_next;
    g_pull_reg <= g_pull_next;
    stby_reg <= stby_next;
    rdata_reg <= rdata_next;
    f_pin_reg <= f_pin_next;
    f_oe_reg <= f_oe_next;
    f_in_reg <= f_in_next;
    g_pin_reg <= g_pin_next;
    g_oe_reg <= g_oe_next;
    g_pu_reg <= g_pu_next;
    g_in_reg <= g_in_next;
  end

  assign rdata_o = rdata_reg;
  assign f_pin_o = f_pin_reg;
  assign f_pin_oe_o = f_oe_reg;
  assign f_in_o = f_in_reg;
  assign g_pin_o = g_pin_reg;
  assign g_pin_oe_o = g_oe_reg;
  assign g_pull_o = g_pu_reg;
  assign g_in_o = g_in_reg;

  ////////////////////////////////////////////////////////////////////////
  a_reset_dir_clear: assert property (@(posedge core_clk_i)
    !rst_b_i |=> (f_dir_reg == GPB_ZERO && g_dir_reg == GPB_ZERO))
    else $error("direction not cleared by reset");
  a_out_follows_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    1'b1 |=> g_pin_o == ($past(g_data_reg) & GPB_G_MASK))
    else $error("port g pin level differs from latch");
  a_input_not_driven: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (g_dir_reg == GPB_ZERO && $stable(g_dir_reg)) |=> g_pin_oe_o == GPB_ZERO)
    else $error("input pin driven");
  a_write_reaches_pin: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (wr_i && addr_i == GPB_OFS_F_DATA) |=> ##1
      f_pin_o == ($past(wdata_i, 2) & GPB_F_MASK))
    else $error("data write not on pin");
  a_standby_forces_z: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    force_z |=> (f_pin_oe_o == GPB_ZERO && g_pin_oe_o == GPB_ZERO))
    else $error("pin driven during forced standby");
  a_blocked_in_low: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (force_z && f_irq_en_i == GPB_ZERO) |=> f_in_o == GPB_ZERO)
    else $error("blocked input not low");
  a_rmw_reads_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (rd_i && rmw_i && addr_i == GPB_OFS_G_DATA && !wr_i) |=>
      rdata_o == $past(g_data_reg))
    else $error("rmw read not latch");
  a_pull_off_low: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    1'b1 |=> ((g_pull_o & g_pin_oe_o & ~g_pin_o) == GPB_ZERO))
    else $error("pull-up on while driving low");
  a_unused_read_zero: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (rd_i && addr_i == GPB_OFS_G_DIR) |=> (rdata_o & ~GPB_G_MASK) == GPB_ZERO)
    else $error("unassigned bit reads one");

  ////////////////////////////////////////////////////////////////////////
  // Drive enables one cycle behind direction and latch
  a_f_dir_drives: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    !force_z |=> f_pin_oe_o ==
      ($past(f_dir_reg) & ~($past(f_data_reg) & F_OPEN_DRAIN)))
    else $error("port f drive differs from direction");
  a_g_dir_drives: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    !force_z |=> g_pin_oe_o ==
      ($past(g_dir_reg) & ~($past(g_data_reg) & G_OPEN_DRAIN)))
    else $error("port g drive differs from direction");
  a_f_out_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    1'b1 |=> f_pin_o == $past(f_data_reg))
    else $error("port f pin level differs from latch");
  a_g_write_pin: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (wr_i && addr_i == GPB_OFS_G_DATA) |=> ##1
      g_pin_o == ($past(wdata_i, 2) & GPB_G_MASK))
    else $error("port g data write not on pin");

  // Latch takes every write, whatever the direction
  a_f_write_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (wr_i && addr_i == GPB_OFS_F_DATA) |=>
      f_data_reg == ($past(wdata_i) & GPB_F_MASK))
    else $error("port f latch missed write");
  a_g_write_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (wr_i && addr_i == GPB_OFS_G_DATA) |=>
      g_data_reg == ($past(wdata_i) & GPB_G_MASK))
    else $error("port g latch missed write");

  // Read data mixes latch and pin per direction bit
  a_out_read_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (rd_i && !rmw_i && addr_i == GPB_OFS_F_DATA) |=>
      (rdata_o & $past(f_dir_reg)) ==
      ($past(f_data_reg) & $past(f_dir_reg)))
    else $error("port f output bit read not latch");
  a_g_read_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (rd_i && !rmw_i && addr_i == GPB_OFS_G_DATA) |=>
      (rdata_o & $past(g_dir_reg)) ==
      ($past(g_data_reg) & $past(g_dir_reg)))
    else $error("port g output bit read not latch");
  a_in_read_pin: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (rd_i && !rmw_i && addr_i == GPB_OFS_G_DATA) |=>
      (rdata_o & ~$past(g_dir_reg)) ==
      ($past(g_sync) & ~$past(g_dir_reg) & GPB_G_MASK))
    else $error("port g input bit read not pin");
  a_f_rmw_latch: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (rd_i && rmw_i && addr_i == GPB_OFS_F_DATA) |=>
      rdata_o == $past(f_data_reg))
    else $error("port f rmw read not latch");

  // Reset and standby
  a_reset_drops_drive: assert property (@(posedge core_clk_i)
    !rst_b_i |=> (f_pin_oe_o == GPB_ZERO && g_pin_oe_o == GPB_ZERO))
    else $error("pin driven after reset");
  a_g_in_low: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (force_z && g_irq_en_i == GPB_ZERO) |=> g_in_o == GPB_ZERO)
    else $error("port g blocked input not low");
  a_irq_keeps_input: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    force_z |=>
      f_in_o == ($past(f_sync) & $past(f_irq_en_i) & GPB_F_MASK))
    else $error("enabled interrupt input blocked");
  a_select_zero_holds: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (!stby_reg[GPB_SPL_BIT] && stop_watch_i) |=>
      g_pin_oe_o ==
      ($past(g_dir_reg) & ~($past(g_data_reg) & G_OPEN_DRAIN)))
    else $error("pin state changed in standby");

  // Pull-up and open-drain
  a_pull_follows_en: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (g_dir_reg == GPB_ZERO) |=> g_pull_o == $past(g_pull_reg))
    else $error("pull-up differs from enable");
  a_od_releases: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    1'b1 |=> (f_pin_oe_o & f_pin_o & F_OPEN_DRAIN) == GPB_ZERO)
    else $error("open-drain pin driven high");
  a_unused_bits_zero: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    1'b1 |-> ((((f_data_reg | f_dir_reg) & ~GPB_F_MASK) |
      ((g_data_reg | g_dir_reg | g_pull_reg) & ~GPB_G_MASK)) == GPB_ZERO))
    else $error("unassigned bit holds one");
endmodule

//--- gpb_pin_model.sv
`timescale 1ns/1ns
module gpb_pin_model (
  // Clock
  input wire logic core_clk_i,
  // Design side
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pull_i,
  // Far side
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] level_o
);
  logic [7:0] float_reg = 8'h55;
  // Floating pins wander, so a stale level never passes
  always_ff @(posedge core_clk_i) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i])
        level_o[i] = out_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_i[i];
      else if (pull_i[i])
        level_o[i] = 1'b1;
      else
        level_o[i] = float_reg[i];
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
  import gpb_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rmw_i = 1'b0;
  logic stop_watch_i = 1'b0;
  logic [7:0] f_irq_en_i = 8'h00;
  logic [7:0] g_irq_en_i = 8'h00;
  logic [7:0] f_ext = 8'h00;
  logic [7:0] g_ext = 8'h00;
  logic [7:0] g_ext_en = 8'hFF;
  logic [7:0] rdata_o, f_pin_i, f_pin_o, f_pin_oe_o, f_in_o;
  logic [7:0] g_pin_i, g_pin_o, g_pin_oe_o, g_pull_o, g_in_o;
  int err_count = 0;
  int checks = 0;

  always #5 core_clk_i = ~core_clk_i;

  // Bit 2 of port F is built open-drain here
  gpb_port_bank #(.F_OPEN_DRAIN(8'h04), .G_OPEN_DRAIN(8'h00)) u_dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rmw_i(rmw_i),
    .rdata_o(rdata_o), .stop_watch_i(stop_watch_i),
    .f_irq_en_i(f_irq_en_i), .g_irq_en_i(g_irq_en_i),
    .f_pin_i(f_pin_i), .f_pin_o(f_pin_o), .f_pin_oe_o(f_pin_oe_o),
    .f_in_o(f_in_o), .g_pin_i(g_pin_i), .g_pin_o(g_pin_o),
    .g_pin_oe_o(g_pin_oe_o), .g_pull_o(g_pull_o), .g_in_o(g_in_o));

  gpb_pin_model u_f_pins (.core_clk_i(core_clk_i), .out_i(f_pin_o),
    .oe_i(f_pin_oe_o), .pull_i(8'h00), .ext_i(f_ext),
    .ext_en_i(8'hFF), .level_o(f_pin_i));
  gpb_pin_model u_g_pins (.core_clk_i(core_clk_i), .out_i(g_pin_o),
    .oe_i(g_pin_oe_o), .pull_i(g_pull_o), .ext_i(g_ext),
    .ext_en_i(g_ext_en), .level_o(g_pin_i));

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  // Data only valid the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic m,
                    input logic [7:0] exp);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    rmw_i <= m;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    rmw_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  // Covers pin pipeline and two-flop input delay
  task automatic settle();
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    for (int a = 0; a < 7; a++) begin
      rd(a[3:0], 1'b0, 8'h00);
    end
    chk(f_pin_oe_o, 8'h00);
    chk(g_pin_oe_o, 8'h00);
  endtask

  task automatic s_output();
    wr(GPB_OFS_F_DIR, 8'hFF);
    rd(GPB_OFS_F_DIR, 1'b0, 8'h07);
    wr(GPB_OFS_F_DATA, 8'h03);
    settle();
    chk(f_pin_oe_o, 8'h07);
    chk(f_pin_i, 8'h03);
    wr(GPB_OFS_F_DATA, 8'h07);
    settle();
    chk(f_pin_oe_o, 8'h03);
    rd(GPB_OFS_F_DATA, 1'b0, 8'h07);
  endtask

  task automatic s_input();
    wr(GPB_OFS_F_DIR, 8'h00);
    wr(GPB_OFS_F_DATA, 8'h01);
    f_ext <= 8'h02;
    g_ext <= 8'h04;
    settle();
    chk(f_pin_oe_o, 8'h00);
    rd(GPB_OFS_F_DATA, 1'b0, 8'h02);
    rd(GPB_OFS_F_DATA, 1'b1, 8'h01);
    rd(GPB_OFS_G_DATA, 1'b0, 8'h04);
    rd(GPB_OFS_G_DATA, 1'b1, 8'h00);
    wr(GPB_OFS_F_DIR, 8'h07);
    settle();
    chk(f_pin_oe_o & f_pin_o, 8'h01);
  endtask

  task automatic s_pull();
    wr(GPB_OFS_G_PULL, 8'hFF);
    rd(GPB_OFS_G_PULL, 1'b0, 8'h06);
    settle();
    chk(g_pull_o, 8'h06);
    // Released pins must read high through the pull-up
    @(posedge core_clk_i);
    g_ext_en <= 8'h00;
    settle();
    chk(g_in_o, 8'h06);
    @(posedge core_clk_i);
    g_ext_en <= 8'hFF;
    wr(GPB_OFS_G_DATA, 8'h02);
    wr(GPB_OFS_G_DIR, 8'h06);
    settle();
    chk(g_pin_oe_o, 8'h06);
    chk(g_pull_o, 8'h02);
    wr(GPB_OFS_G_PULL, 8'h00);
    settle();
    chk(g_pull_o, 8'h00);
  endtask

  // Peripheral outputs stay off throughout, as software must ensure
  task automatic s_standby();
    @(posedge core_clk_i);
    stop_watch_i <= 1'b1;
    settle();
    chk(f_pin_oe_o, 8'h07);
    chk(g_pin_i, 8'h02);
    chk(f_in_o, 8'h01);
    @(posedge core_clk_i);
    f_irq_en_i <= 8'h02;
    wr(GPB_OFS_STBY, 8'hFF);
    rd(GPB_OFS_STBY, 1'b0, 8'h01);
    settle();
    chk(f_pin_oe_o, 8'h00);
    chk(g_pin_oe_o, 8'h00);
    chk(f_in_o, 8'h02);
    chk(g_in_o, 8'h00);
    @(posedge core_clk_i);
    stop_watch_i <= 1'b0;
    settle();
    chk(f_pin_oe_o, 8'h07);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Second reset with directions set must clear them again
  task automatic s_rereset();
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    settle();
    rd(GPB_OFS_F_DIR, 1'b0, 8'h00);
    rd(GPB_OFS_G_DIR, 1'b0, 8'h00);
    chk(f_pin_oe_o, 8'h00);
    chk(g_pin_oe_o, 8'h00);
  endtask

  task automatic close_out();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    settle();
    s_reset();
    s_output();
    s_input();
    s_pull();
    s_standby();
    s_rereset();
    close_out();
  end

  // Run needs well under 1000 cycles
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule
